// >>> serm_defs.vh
// Constants shared by the serial word-alterable memory sequencer and its command queue.
// Assumes it is included by bare name from design files and defines nothing but macros.
`ifndef SERM_DEFS_VH
`define SERM_DEFS_VH

// ==========================================================================
// Array organisation
`define SERM_WORD_W 14
`define SERM_WORDS 100
`define SERM_INDEX_W 7
`define SERM_GROUP_W 10
`define SERM_ADDR_W 20
`define SERM_ERASED_WORD 14'h3fff

// ==========================================================================
// Mode codes, bit a is the most significant
`define SERM_MODE_STANDBY 3'h0
`define SERM_MODE_RESERVED 3'h1
`define SERM_MODE_ERASE 3'h2
`define SERM_MODE_ACCEPT_ADDR 3'h3
`define SERM_MODE_READ 3'h4
`define SERM_MODE_SHIFT_OUT 3'h5
`define SERM_MODE_WRITE 3'h6
`define SERM_MODE_ACCEPT_DATA 3'h7

// ==========================================================================
// Queued alteration commands
`define SERM_OP_ERASE 1'b0
`define SERM_OP_WRITE 1'b1
`define SERM_FIFO_DEPTH 32
`define SERM_FIFO_PTR_W 5

// ==========================================================================
// Timing
`define SERM_CLK_PERIOD_NS 50
`define SERM_ALTER_TIME_US 10
`define SERM_ALTER_CYCLES ((`SERM_ALTER_TIME_US * 1000 + `SERM_CLK_PERIOD_NS - 1) / `SERM_CLK_PERIOD_NS)
`define SERM_ALTER_CNT_W 18

`endif

// >>> serm_fifo.v
// Synchronous first-in first-out queue with valid and ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps

module serm_fifo #(
	parameter WIDTH = 22,
	parameter DEPTH = 32,
	parameter PTR_W = 5
) (
	input wire sys_clk_in,
	input wire srst_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);

	reg [WIDTH-1:0] store_q [0:DEPTH-1];
	reg [PTR_W:0] wr_ptr_q;
	reg [PTR_W:0] rd_ptr_q;
	wire push;
	wire pop;
	wire full;
	wire empty;

	// ==========================================================================
	// Status
	// The extra pointer bit tells a full queue from an empty one.
	assign empty = (wr_ptr_q == rd_ptr_q);
	assign full = (wr_ptr_q[PTR_W-1:0] == rd_ptr_q[PTR_W-1:0]) &&
		(wr_ptr_q[PTR_W] != rd_ptr_q[PTR_W]);
	assign in_ready_out = ~full;
	assign out_valid_out = ~empty;
	assign out_data_out = store_q[rd_ptr_q[PTR_W-1:0]];
	assign push = in_valid_in & ~full;
	assign pop = out_ready_in & ~empty;

	// ==========================================================================
	// Storage and pointers
	// Storage holds no reset; only the pointers define what is valid.
	always @(posedge sys_clk_in) begin
		if (push) begin
			store_q[wr_ptr_q[PTR_W-1:0]] <= in_data_in;
		end
	end

	// Pointers advance only on an accepted transfer.
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			wr_ptr_q <= {(PTR_W+1){1'b0}};
			rd_ptr_q <= {(PTR_W+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + {{PTR_W{1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + {{PTR_W{1'b0}}, 1'b1};
			end
		end
	end

endmodule

// >>> serm_sequencer.v
// Mode sequencer and serial data path of a word-alterable serial memory of 100 x 14 bits.
// Assumes the host clock, mode code and data pin arrive asynchronously from outside.
`timescale 1ns/1ps
`include "serm_defs.vh"

module serm_sequencer #(
	parameter ALTER_CYCLES = `SERM_ALTER_CYCLES,
	parameter CNT_W = `SERM_ALTER_CNT_W,
	parameter FIFO_DEPTH = `SERM_FIFO_DEPTH,
	parameter FIFO_PTR_W = `SERM_FIFO_PTR_W
) (
	input wire sys_clk_in,
	input wire srst_in,
	input wire serial_clk_in,
	input wire mode_select_bit_a_in,
	input wire mode_select_bit_b_in,
	input wire mode_select_bit_c_in,
	input wire data_in,
	output wire data_out,
	output wire data_oe_out,
	output wire busy_out
);

	localparam WORD_W = `SERM_WORD_W;
	localparam IDX_W = `SERM_INDEX_W;
	localparam CMD_W = 1 + IDX_W + WORD_W;
	// The terminal count is cut to the counter width on purpose.
	localparam integer ALTER_LAST_I = ALTER_CYCLES - 1;
	localparam [CNT_W-1:0] ALTER_LAST = ALTER_LAST_I[CNT_W-1:0];
	localparam [1:0] ENG_IDLE = 2'b01;
	localparam [1:0] ENG_BUSY = 2'b10;

	// Converts one ten-bit group into {valid, digit}; valid needs exactly one bit set.
	function [4:0] serm_digit;
		input [9:0] grp;
		integer i;
		reg [3:0] ones;
		begin
			serm_digit = 5'h00;
			ones = 4'h0;
			for (i = 0; i < 10; i = i + 1) begin
				if (grp[i]) begin
					ones = ones + 4'h1;
					serm_digit[3:0] = i[3:0];
				end
			end
			serm_digit[4] = (ones == 4'h1);
		end
	endfunction

	// ==========================================================================
	// Input synchronisers
	reg [2:0] mode_s1_q;
	reg [2:0] mode_s2_q;
	reg clk_s1_q;
	reg clk_s2_q;
	reg clk_prev_q;
	reg data_s1_q;
	reg data_s2_q;

	// Every pin passes two flops; the rising edge is judged on the second stage only.
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			mode_s1_q <= `SERM_MODE_STANDBY;
			mode_s2_q <= `SERM_MODE_STANDBY;
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_prev_q <= 1'b0;
			data_s1_q <= 1'b0;
			data_s2_q <= 1'b0;
		end else begin
			mode_s1_q <= {mode_select_bit_a_in, mode_select_bit_b_in, mode_select_bit_c_in};
			mode_s2_q <= mode_s1_q;
			clk_s1_q <= serial_clk_in;
			clk_s2_q <= clk_s1_q;
			clk_prev_q <= clk_s2_q;
			data_s1_q <= data_in;
			data_s2_q <= data_s1_q;
		end
	end

	// ==========================================================================
	// Address decode
	reg [`SERM_ADDR_W-1:0] addr_q;
	wire [4:0] tens;
	wire [4:0] units;
	wire addr_ok;
	wire [IDX_W-1:0] word_idx;

	// Tens digit sits in the upper group because it is shifted in first.
	assign tens = serm_digit(addr_q[19:10]);
	assign units = serm_digit(addr_q[9:0]);
	assign addr_ok = tens[4] & units[4];
	// Index is tens * 10 + units, formed by shifts to stay within seven bits.
	assign word_idx = {tens[3:0], 3'h0} + {2'h0, tens[3:0], 1'b0} + {3'h0, units[3:0]};

	// ==========================================================================
	// Command queue toward the array engine
	reg cmd_pend_q;
	reg [CMD_W-1:0] cmd_q;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [CMD_W-1:0] fifo_out_data;
	reg [1:0] eng_state_q;

	// The engine drains one alteration at a time, so a burst of them fills the queue.
	serm_fifo #(
		.WIDTH(CMD_W),
		.DEPTH(FIFO_DEPTH),
		.PTR_W(FIFO_PTR_W)
	) u_queue (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.in_valid_in(cmd_pend_q),
		.in_ready_out(fifo_in_ready),
		.in_data_in(cmd_q),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_out_ready),
		.out_data_out(fifo_out_data)
	);

	// ==========================================================================
	// Nonvolatile array and alteration engine
	reg [WORD_W-1:0] mem_q [0:`SERM_WORDS-1];
	reg [CNT_W-1:0] alter_cnt_q;
	reg alter_op_q;
	reg [IDX_W-1:0] alter_idx_q;
	reg [WORD_W-1:0] alter_data_q;

	assign fifo_out_ready = (eng_state_q == ENG_IDLE);

	// The array holds no reset because its contents must outlive a reset.
	always @(posedge sys_clk_in) begin
		if (!srst_in && (eng_state_q == ENG_BUSY) && (alter_cnt_q == ALTER_LAST)) begin
			if (alter_op_q == `SERM_OP_ERASE) begin
				mem_q[alter_idx_q] <= `SERM_ERASED_WORD;
			end else begin
				// Programming only clears bits, so an unerased word cannot be raised.
				mem_q[alter_idx_q] <= mem_q[alter_idx_q] & alter_data_q;
			end
		end
	end

	// Each alteration holds the engine for the full erase or write time.
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			eng_state_q <= ENG_IDLE;
			alter_cnt_q <= {CNT_W{1'b0}};
			alter_op_q <= `SERM_OP_ERASE;
			alter_idx_q <= {IDX_W{1'b0}};
			alter_data_q <= {WORD_W{1'b0}};
		end else begin
			case (eng_state_q)
				ENG_IDLE: begin
					alter_cnt_q <= {CNT_W{1'b0}};
					if (fifo_out_valid) begin
						{alter_op_q, alter_idx_q, alter_data_q} <= fifo_out_data;
						eng_state_q <= ENG_BUSY;
					end
				end
				ENG_BUSY: begin
					alter_cnt_q <= alter_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
					if (alter_cnt_q == ALTER_LAST) begin
						eng_state_q <= ENG_IDLE;
					end
				end
				default: begin
					eng_state_q <= ENG_IDLE;
				end
			endcase
		end
	end

	// ==========================================================================
	// Mode sequencer and serial registers
	reg [2:0] mode_prev_q;
	reg [WORD_W-1:0] data_q;
	reg oe_q;
	reg read_pend_q;
	wire clk_rise;
	wire mode_entry;
	wire read_go;

	// Host clock rising edges carry all serial traffic; none arrive while stopped.
	assign clk_rise = clk_s2_q & ~clk_prev_q & ~cmd_pend_q;
	// A new mode is only taken once any earlier alteration has entered the queue.
	assign mode_entry = (mode_s2_q != mode_prev_q) & ~cmd_pend_q;
	// A read waits until every queued alteration has reached the array.
	assign read_go = read_pend_q & ~cmd_pend_q & ~fifo_out_valid & (eng_state_q == ENG_IDLE);

	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			mode_prev_q <= `SERM_MODE_STANDBY;
			addr_q <= {`SERM_ADDR_W{1'b0}};
			data_q <= {WORD_W{1'b0}};
			oe_q <= 1'b0;
			read_pend_q <= 1'b0;
			cmd_pend_q <= 1'b0;
			cmd_q <= {CMD_W{1'b0}};
		end else begin
			if (!cmd_pend_q) begin
				mode_prev_q <= mode_s2_q;
			end
			oe_q <= (mode_s2_q == `SERM_MODE_SHIFT_OUT);
			if (cmd_pend_q && fifo_in_ready) begin
				cmd_pend_q <= 1'b0;
			end
			// Alterations to an invalid address are dropped silently.
			if (mode_entry && addr_ok) begin
				if (mode_s2_q == `SERM_MODE_ERASE) begin
					cmd_pend_q <= 1'b1;
					cmd_q <= {`SERM_OP_ERASE, word_idx, `SERM_ERASED_WORD};
				end else if (mode_s2_q == `SERM_MODE_WRITE) begin
					cmd_pend_q <= 1'b1;
					cmd_q <= {`SERM_OP_WRITE, word_idx, data_q};
				end
			end
			if (mode_entry && (mode_s2_q == `SERM_MODE_READ)) begin
				read_pend_q <= 1'b1;
			end else if (read_go) begin
				read_pend_q <= 1'b0;
			end
			if (read_go) begin
				if (addr_ok) begin
					data_q <= mem_q[word_idx];
				end
			end else if (clk_rise) begin
				case (mode_s2_q)
					`SERM_MODE_ACCEPT_ADDR: begin
						addr_q <= {addr_q[`SERM_ADDR_W-2:0], data_s2_q};
					end
					`SERM_MODE_ACCEPT_DATA: begin
						data_q <= {data_q[WORD_W-2:0], data_s2_q};
					end
					`SERM_MODE_SHIFT_OUT: begin
						data_q <= {data_q[WORD_W-2:0], 1'b0};
					end
					default: begin
						// Standby, the unused code and the timed modes hold both registers.
						addr_q <= addr_q;
					end
				endcase
			end
		end
	end

	// ==========================================================================
	// Outputs
	// The most significant data bit is always at the pin while driven.
	assign data_out = data_q[WORD_W-1];
	assign data_oe_out = oe_q;
	assign busy_out = cmd_pend_q | read_pend_q | fifo_out_valid | (eng_state_q == ENG_BUSY);

endmodule

// >>> serm_props.sv
// Checker for the serial memory sequencer; it sees only the top module's ports.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ps
module serm_props #(
	parameter ALTER_CYCLES = 20,
	parameter FIFO_DEPTH = 32
) (
	input wire sys_clk_in,
	input wire srst_in,
	input wire serial_clk_in,
	input wire mode_select_bit_a_in,
	input wire mode_select_bit_b_in,
	input wire mode_select_bit_c_in,
	input wire data_out,
	input wire data_oe_out,
	input wire busy_out
);
	// ==========================================================================
	// Helper logic
	localparam int BUSY_MAX = (FIFO_DEPTH + 1) * (ALTER_CYCLES + 16);
	wire [2:0] mode = {mode_select_bit_a_in, mode_select_bit_b_in, mode_select_bit_c_in};
	reg [7:0] since_q;
	reg [31:0] busy_q;
	// Age of the last host clock rise; it saturates so a long idle spell cannot wrap.
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			since_q <= 8'hff;
			busy_q <= 32'h0;
		end else begin
			since_q <= $rose(serial_clk_in) ? 8'h00 : since_q + {7'h0, since_q != 8'hff};
			busy_q <= busy_out ? busy_q + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	// ==========================================================================
	// Assertions
	a_reset_quiet: assert property (disable iff (1'b0) srst_in |=> !data_oe_out && !busy_out)
		else $error("Driver or busy active after reset.");
	a_standby_float: assert property ((mode == 3'h0)[*5] |-> !data_oe_out)
		else $error("Pin driven in standby.");
	a_standby_keep: assert property ((mode == 3'h0 && !busy_out)[*5] |-> $stable(data_out))
		else $error("Data register moved in standby.");
	a_addr_keep: assert property ((mode == 3'h3 && !busy_out)[*5] |-> $stable(data_out))
		else $error("Data register moved during address entry.");
	a_oe_other: assert property ((mode != 3'h5 && !busy_out)[*5] |-> !data_oe_out)
		else $error("Pin driven outside shift out.");
	a_oe_shift: assert property ((mode == 3'h5 && !busy_out)[*5] |-> data_oe_out)
		else $error("Pin not driven in shift out.");
	a_shift_clk: assert property (data_oe_out && $past(data_oe_out) && $changed(data_out)
		|-> since_q <= 8'd6)
		else $error("Output bit moved without a host clock.");
	a_busy_bound: assert property (busy_q <= BUSY_MAX)
		else $error("Alteration never finished.");
	c_shift: cover property (data_oe_out && $changed(data_out));
	c_alter: cover property (busy_q == 32'd20);
	c_standby: cover property ((mode == 3'h0)[*5]);
endmodule

bind serm_sequencer serm_props #(.ALTER_CYCLES(ALTER_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_serm_props (
	.sys_clk_in(sys_clk_in), .srst_in(srst_in), .serial_clk_in(serial_clk_in),
	.mode_select_bit_a_in(mode_select_bit_a_in), .mode_select_bit_b_in(mode_select_bit_b_in),
	.mode_select_bit_c_in(mode_select_bit_c_in), .data_out(data_out),
	.data_oe_out(data_oe_out), .busy_out(busy_out));

// >>> serm_host_model.sv
// Host controller model: mode code, host clock and the shared data pin.
// Assumes the device samples everything on the system clock after synchronising.
`timescale 1ns/1ps
module serm_host_model (
	input wire sys_clk_in,
	input wire dev_data_in,
	input wire dev_oe_in,
	output reg serial_clk_out,
	output reg mode_select_bit_a_out,
	output reg mode_select_bit_b_out,
	output reg mode_select_bit_c_out,
	output wire pin_out
);
	reg drv_en = 1'b0;
	reg drv_q = 1'b0;
	int gap = 0;
	// A released pin shows the inverse of the last bit, so a stale level never reads back.
	assign pin_out = dev_oe_in ? dev_data_in : (drv_en ? drv_q : ~drv_q);
	initial begin
		serial_clk_out = 1'b0;
		{mode_select_bit_a_out, mode_select_bit_b_out, mode_select_bit_c_out} = 3'h0;
	end
	// Mode moves only between pulses; the unused code is never issued.
	task set_mode(input logic [2:0] m);
		@(negedge sys_clk_in);
		drv_en = 1'b0;
		{mode_select_bit_a_out, mode_select_bit_b_out, mode_select_bit_c_out} = m;
		repeat (6 + gap) @(negedge sys_clk_in);
	endtask
	// One host clock pulse; the bit is set up early and held well past the rise.
	task pulse(input logic b, input logic en);
		@(negedge sys_clk_in);
		drv_en = en;
		drv_q = b;
		repeat (2 + gap) @(negedge sys_clk_in);
		serial_clk_out = 1'b1;
		repeat (5) @(negedge sys_clk_in);
		serial_clk_out = 1'b0;
		repeat (3 + gap) @(negedge sys_clk_in);
	endtask
endmodule

// >>> tb_serm_sequencer.sv
// Self-checking bench for the sequencer with a host model on its pins.
// Assumes the design, its queue and the constants header are compiled first.
`timescale 1ns/1ps
module tb_serm_sequencer;
	logic sys_clk_in = 1'b0;
	logic srst_in = 1'b1;
	wire sck, ma, mb, mc, pin, dout, doe, busy;
	int errors = 0;
	int cmp_count = 0;
	int idx;
	logic [13:0] d;
	logic [13:0] mem [0:99];
	logic [99:0] used = '0;
	initial forever #25 sys_clk_in = ~sys_clk_in;
	// A short alteration time keeps the run brief; no expectation depends on it.
	serm_sequencer #(.ALTER_CYCLES(20)) u_serm_sequencer (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in), .serial_clk_in(sck),
		.mode_select_bit_a_in(ma), .mode_select_bit_b_in(mb), .mode_select_bit_c_in(mc),
		.data_in(pin), .data_out(dout), .data_oe_out(doe), .busy_out(busy));
	serm_host_model u_serm_host_model (.sys_clk_in(sys_clk_in), .dev_data_in(dout),
		.dev_oe_in(doe), .serial_clk_out(sck), .mode_select_bit_a_out(ma),
		.mode_select_bit_b_out(mb), .mode_select_bit_c_out(mc), .pin_out(pin));
	// ==========================================================================
	// Helpers
	function logic [19:0] addr_code(input int n);
		return {10'h001 << (n / 10), 10'h001 << (n % 10)};
	endfunction
	task check(input logic [13:0] seen, input logic [13:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("compares %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// The host clock keeps running while an alteration or read is in progress.
	task go(input logic [2:0] m);
		u_serm_host_model.set_mode(m);
		for (int i = 0; i < 500 && busy !== 1'b0; i++) begin
			u_serm_host_model.pulse(1'b0, 1'b0);
		end
		check({13'h0, busy}, 14'h0);
	endtask
	// Tens group first, each group sent from digit nine down to digit zero.
	task set_addr(input int n);
		logic [19:0] v;
		v = addr_code(n);
		go(3'h3);
		for (int i = 19; i >= 0; i--) u_serm_host_model.pulse(v[i], 1'b1);
	endtask
	task load(input logic [13:0] w);
		go(3'h7);
		for (int i = 13; i >= 0; i--) u_serm_host_model.pulse(w[i], 1'b1);
	endtask
	// Read, idle in standby with the clock running, then shift the word out.
	task readback(input int n);
		set_addr(n);
		go(3'h4);
		u_serm_host_model.set_mode(3'h0);
		repeat (3) u_serm_host_model.pulse(1'($urandom), 1'b1);
		check({13'h0, doe}, 14'h0);
		u_serm_host_model.set_mode(3'h5);
		check({13'h0, doe}, 14'h1);
		for (int i = 13; i >= 0; i--) begin
			check({13'h0, dout}, {13'h0, mem[n][i]});
			u_serm_host_model.pulse(1'b0, 1'b0);
		end
		check({13'h0, dout}, 14'h0);
		u_serm_host_model.set_mode(3'h0);
	endtask
	// ==========================================================================
	// Main sequence
	initial begin
		void'($urandom(32'h85a9));
		repeat (3) @(negedge sys_clk_in);
		srst_in = 1'b0;
		check({12'h0, doe, busy}, 14'h0);
		for (int k = 0; k < 8; k++) begin
			u_serm_host_model.gap = k % 3;
			idx = (k == 0) ? 0 : (k == 1) ? 99 : $urandom_range(99);
			set_addr(idx);
			go(3'h2);
			mem[idx] = 14'h3fff;
			readback(idx);
			d = 14'($urandom);
			load(d);
			go(3'h6);
			mem[idx] = mem[idx] & d;
			readback(idx);
			// A second erase and write cycle must replace the first word entirely.
			go(3'h2);
			mem[idx] = 14'h3fff;
			d = 14'($urandom);
			load(d);
			go(3'h6);
			mem[idx] = mem[idx] & d;
			readback(idx);
			used[idx] = 1'b1;
		end
		for (int k = 0; k < 100; k++) if (used[k]) readback(k);
		summarize();
	end
	initial begin
		#(50 * 50000);
		errors++;
		summarize();
	end
endmodule
